// *** logic/dac_cfg_pkg.sv ***
// Purpose: Constants and carriers for the DAC filter, mute and pin bank
// Assumes: 8-bit registers reached through the internal register port
// Notes:
package dac_cfg_pkg;

    localparam logic [7:0] ADDR_EMPH_RAMP  = 8'h06;
    localparam logic [7:0] ADDR_FILT_MUTE  = 8'h07;
    localparam logic [7:0] ADDR_PIN_CFG    = 8'h08;
    localparam logic [7:0] ADDR_SPARE      = 8'h09;
    localparam logic [7:0] ADDR_PIN_INVERT = 8'h0B;
    localparam logic [7:0] ADDR_STATUS     = 8'h40;
    localparam logic [7:0] ADDR_PIN_LEVEL  = 8'h41;

    localparam logic [7:0] RST_EMPH_RAMP   = 8'h4A;
    localparam logic [7:0] RST_FILT_MUTE   = 8'h40;
    localparam logic [7:0] RST_PIN_CFG     = 8'h88;
    localparam logic [7:0] RST_SPARE       = 8'h88;
    localparam logic [3:0] RST_PIN_INVERT  = 4'h0;

    localparam int AUTO_EMPH_BIT  = 7;
    localparam int EMPH_OFF_BIT   = 6;
    localparam int CURVE_LSB      = 4;
    localparam int RAMP_LSB       = 0;
    localparam int FIR_LSB        = 5;
    localparam int CUTOFF_LSB     = 1;
    localparam int MUTE_BIT       = 0;
    localparam int FUNC_LSB       = 0;
    localparam int ST_AUTOMUTE    = 0;
    localparam int ST_LOCK        = 1;

    localparam logic [3:0] FN_AUTOMUTE  = 4'h0;
    localparam logic [3:0] FN_LOCK      = 4'h1;
    localparam logic [3:0] FN_VOL_MIN   = 4'h2;
    localparam logic [3:0] FN_MCLK      = 4'h3;
    localparam logic [3:0] FN_IRQ       = 4'h4;
    localparam logic [3:0] FN_CONV_CLK  = 4'h5;
    localparam logic [3:0] FN_FORCE_LO  = 4'h7;
    localparam logic [3:0] FN_STD_IN    = 4'h8;
    localparam logic [3:0] FN_IN_SEL    = 4'h9;
    localparam logic [3:0] FN_MUTE_IN   = 4'hA;
    localparam logic [3:0] FN_AUX_IN    = 4'hD;
    localparam logic [3:0] FN_GROUNDED  = 4'hE;
    localparam logic [3:0] FN_FORCE_HI  = 4'hF;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic       emph_on;
        logic [1:0] emph_curve;
        logic [2:0] ramp_speed;
        logic [2:0] fir_response;
        logic       fir_active;
        logic [1:0] second_stage_cutoff;
        logic       mute_all;
    } filt_cfg_t;

endpackage

// *** logic/dac_filter_mute_gpio_config.sv ***
// Purpose: Register bank for emphasis, filters, mute and the pin
// Assumes: I2C engine elsewhere turns bus frames into reg_req strobes
// Notes: Clocks on the pin are muxed straight through, not retimed
`timescale 1ns/1ps
module dac_filter_mute_gpio_config
(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    // Register port
    input  wire dac_cfg_pkg::reg_req_t  reg_req,
    output logic [7:0]                  reg_rdata,
    output logic                        reg_rvalid,
    // Device state
    input  wire logic                   rx_present,
    input  wire logic                   rx_emph_valid,
    input  wire logic                   dsd_input,
    input  wire logic                   automute_status,
    input  wire logic                   lock_status,
    input  wire logic                   volume_at_min,
    input  wire logic                   outputs_grounded,
    input  wire logic                   conv_clk,
    // Filter and mute controls
    output dac_cfg_pkg::filt_cfg_t      filt_cfg,
    output logic                        input_toggle,
    output logic                        aux_converter_input,
    output logic                        aux_converter_sel,
    // General-purpose pin
    input  wire logic                   pin_i,
    output logic                        pin_o,
    output logic                        pin_oe
);
    import dac_cfg_pkg::*;

    logic [7:0] emphasis_and_ramp_ctrl;
    logic [7:0] filter_and_mute_ctrl;
    logic [7:0] pin_function_config;
    logic [7:0] spare_config;
    logic [3:0] pin_invert;
    logic       pin_meta;
    logic       pin_sync;
    logic       status_irq;
    logic       prev_automute;
    logic       prev_lock;
    logic       pin_level_q;

    wire logic [3:0] pin1_function_code = pin_function_config[FUNC_LSB +: 4];

    function automatic logic drives_pin(input logic [3:0] code);
        drives_pin = (code <= FN_CONV_CLK) || (code == FN_FORCE_LO)
                  || (code == FN_GROUNDED) || (code == FN_FORCE_HI);
    endfunction

    function automatic logic hit(input reg_req_t r, input logic [7:0] a);
        hit = (r.addr == a);
    endfunction

    // Register writes
    wire logic wr_emph  = reg_req.wr && hit(reg_req, ADDR_EMPH_RAMP);
    wire logic wr_filt  = reg_req.wr && hit(reg_req, ADDR_FILT_MUTE);
    wire logic wr_pin   = reg_req.wr && hit(reg_req, ADDR_PIN_CFG);
    wire logic wr_spare = reg_req.wr && hit(reg_req, ADDR_SPARE);
    wire logic wr_inv   = reg_req.wr && hit(reg_req, ADDR_PIN_INVERT);
    wire logic rd_stat  = reg_req.rd && hit(reg_req, ADDR_STATUS);

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            emphasis_and_ramp_ctrl <= RST_EMPH_RAMP;
            filter_and_mute_ctrl   <= RST_FILT_MUTE;
            pin_function_config    <= RST_PIN_CFG;
            spare_config           <= RST_SPARE;
            pin_invert             <= RST_PIN_INVERT;
        end
        else
        begin
            if (wr_emph)
                emphasis_and_ramp_ctrl <= reg_req.wdata;
            if (wr_filt)
                filter_and_mute_ctrl <= reg_req.wdata;
            if (wr_pin)
                pin_function_config <= reg_req.wdata;
            if (wr_spare)
                spare_config <= reg_req.wdata;
            if (wr_inv)
                pin_invert <= reg_req.wdata[3:0];
        end
    end

    // Pin input passes two flops since it comes from outside
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            pin_meta <= pin_i;
            pin_sync <= pin_meta;
        end
    end

    // Status change flag; a change in the reading cycle still sets it
    wire logic status_changed = (automute_status != prev_automute)
                             || (lock_status != prev_lock);
    wire logic next_status_irq = status_changed
                              || (status_irq && !rd_stat);

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            // Track levels in reset so release raises no false change
            prev_automute <= automute_status;
            prev_lock     <= lock_status;
            status_irq    <= 1'b0;
        end
        else
        begin
            prev_automute <= automute_status;
            prev_lock     <= lock_status;
            status_irq    <= next_status_irq;
        end
    end

    // Captured level, follows the pin in standard input use and held otherwise
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            pin_level_q <= 1'b0;
        else if (pin1_function_code == FN_STD_IN)
            pin_level_q <= pin_sync;
    end

    // Read path
    wire logic [7:0] status_word = {6'h00, lock_status, automute_status};
    wire logic [7:0] read_mux =
        hit(reg_req, ADDR_EMPH_RAMP)  ? emphasis_and_ramp_ctrl :
        hit(reg_req, ADDR_FILT_MUTE)  ? filter_and_mute_ctrl :
        hit(reg_req, ADDR_PIN_CFG)    ? pin_function_config :
        hit(reg_req, ADDR_SPARE)      ? spare_config :
        hit(reg_req, ADDR_PIN_INVERT) ? {4'h0, pin_invert} :
        hit(reg_req, ADDR_STATUS)     ? status_word :
        hit(reg_req, ADDR_PIN_LEVEL)  ? {7'h00, pin_level_q} :
        8'h00;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd)
                reg_rdata <= read_mux;
        end
    end

    // Filter controls
    wire logic auto_emph = emphasis_and_ramp_ctrl[AUTO_EMPH_BIT]
                        && rx_present && rx_emph_valid;
    wire logic pin_mute  = (pin1_function_code == FN_MUTE_IN) && pin_sync;
    wire logic next_emph_on = !emphasis_and_ramp_ctrl[EMPH_OFF_BIT]
                           || auto_emph;
    wire logic next_mute = filter_and_mute_ctrl[MUTE_BIT] || pin_mute;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            filt_cfg            <= '0;
            input_toggle        <= 1'b0;
            aux_converter_input <= 1'b0;
        end
        else
        begin
            filt_cfg.emph_on <= next_emph_on;
            filt_cfg.emph_curve <=
                emphasis_and_ramp_ctrl[CURVE_LSB +: 2];
            filt_cfg.ramp_speed <=
                emphasis_and_ramp_ctrl[RAMP_LSB +: 3];
            filt_cfg.fir_response <=
                filter_and_mute_ctrl[FIR_LSB +: 3];
            filt_cfg.fir_active <= !dsd_input;
            filt_cfg.second_stage_cutoff <=
                filter_and_mute_ctrl[CUTOFF_LSB +: 2];
            filt_cfg.mute_all <= next_mute;
            input_toggle <= (pin1_function_code == FN_IN_SEL)
                         && pin_sync;
            aux_converter_input <= pin_sync;
        end
    end

    assign aux_converter_sel = (pin1_function_code == FN_AUX_IN);

    // Pin output level before inversion
    logic next_pin_level;
    always_comb
    begin
        next_pin_level = 1'b0;
        case (pin1_function_code)
            FN_AUTOMUTE: next_pin_level = automute_status;
            FN_LOCK:     next_pin_level = lock_status;
            FN_VOL_MIN:  next_pin_level = volume_at_min;
            FN_IRQ:      next_pin_level = next_status_irq;
            FN_FORCE_LO: next_pin_level = 1'b0;
            FN_GROUNDED: next_pin_level = outputs_grounded;
            FN_FORCE_HI: next_pin_level = 1'b1;
            default:     next_pin_level = 1'b0;
        endcase
    end

    logic pin_q;
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            pin_q <= 1'b0;
        else
            pin_q <= next_pin_level ^ pin_invert[0];
    end

    // Clocks bypass the flop, which samples on the ref_clk edge and would freeze ref_clk
    wire logic clk_sel = (pin1_function_code == FN_MCLK) ? ref_clk :
                         conv_clk;
    wire logic clk_code = (pin1_function_code == FN_MCLK)
                       || (pin1_function_code == FN_CONV_CLK);
    assign pin_o  = clk_code ? (clk_sel ^ pin_invert[0]) : pin_q;
    assign pin_oe = drives_pin(pin1_function_code);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_auto_emph;
        (emphasis_and_ramp_ctrl[AUTO_EMPH_BIT] && rx_present
            && rx_emph_valid) |=> filt_cfg.emph_on;
    endproperty
    a_auto_emph: assert property (p_auto_emph)
        else $error("auto emphasis not engaged");

    property p_emph_off;
        (emphasis_and_ramp_ctrl[EMPH_OFF_BIT] && !rx_present)
            |=> !filt_cfg.emph_on;
    endproperty
    a_emph_off: assert property (p_emph_off)
        else $error("emphasis on while disabled");

    property p_curve;
        !wr_emph |=> filt_cfg.emph_curve
            == $past(emphasis_and_ramp_ctrl[CURVE_LSB +: 2]);
    endproperty
    a_curve: assert property (p_curve)
        else $error("emphasis curve mismatch");

    property p_fir_pcm;
        dsd_input |=> !filt_cfg.fir_active;
    endproperty
    a_fir_pcm: assert property (p_fir_pcm)
        else $error("fir active for dsd input");

    property p_mute;
        filter_and_mute_ctrl[MUTE_BIT] |=> filt_cfg.mute_all;
    endproperty
    a_mute: assert property (p_mute)
        else $error("global mute not applied");

    sequence s_irq_code;
        pin1_function_code == FN_IRQ && !wr_pin && !wr_inv;
    endsequence
    sequence s_status_move;
        $changed(lock_status) || $changed(automute_status);
    endsequence
    property p_irq;
        (s_irq_code and s_status_move) |=> pin_o == !pin_invert[0];
    endproperty
    a_irq: assert property (p_irq)
        else $error("status change not flagged on pin");

    property p_irq_clear;
        (status_irq && rd_stat && !status_changed) |=> !status_irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("status read did not clear flag");

    property p_force;
        (pin1_function_code == FN_FORCE_HI && !wr_pin && !wr_inv)
            |=> pin_oe && pin_o == !pin_invert[0];
    endproperty
    a_force: assert property (p_force)
        else $error("forced high not driven");

    property p_input_tristate;
        (pin1_function_code == FN_STD_IN
            || pin1_function_code == FN_MUTE_IN) |-> !pin_oe;
    endproperty
    a_input_tristate: assert property (p_input_tristate)
        else $error("pin driven in input use");

    property p_pin_mute;
        (pin1_function_code == FN_MUTE_IN && !wr_pin) ##0 pin_sync
            |=> filt_cfg.mute_all;
    endproperty
    a_pin_mute: assert property (p_pin_mute)
        else $error("pin mute not applied");

    property p_lock_mirror;
        (pin1_function_code == FN_LOCK && !wr_pin && !wr_inv)
            |=> pin_o == ($past(lock_status) ^ pin_invert[0]);
    endproperty
    a_lock_mirror: assert property (p_lock_mirror)
        else $error("lock not mirrored on pin");

    property p_automute_mirror;
        (pin1_function_code == FN_AUTOMUTE && !wr_pin && !wr_inv)
            |=> pin_o == ($past(automute_status) ^ pin_invert[0]);
    endproperty
    a_automute_mirror: assert property (p_automute_mirror)
        else $error("automute not mirrored on pin");

    property p_grounded_mirror;
        (pin1_function_code == FN_GROUNDED && !wr_pin && !wr_inv)
            |=> pin_o == ($past(outputs_grounded) ^ pin_invert[0]);
    endproperty
    a_grounded_mirror: assert property (p_grounded_mirror)
        else $error("ground ramp state not on pin");

    property p_force_low;
        (pin1_function_code == FN_FORCE_LO && !wr_pin && !wr_inv)
            |=> pin_oe && pin_o == pin_invert[0];
    endproperty
    a_force_low: assert property (p_force_low)
        else $error("forced low not driven");

    property p_capture;
        (pin1_function_code == FN_STD_IN)
            |=> pin_level_q == $past(pin_sync);
    endproperty
    a_capture: assert property (p_capture)
        else $error("pin level not captured");

    property p_toggle;
        (pin1_function_code == FN_IN_SEL)
            |=> input_toggle == $past(pin_sync);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("input toggle not following pin");

endmodule

// *** sim/pin_far_end.sv ***
// Purpose: Far-end logic on the general-purpose pin
// Assumes: No pull-up or pull-down on the pin
// Notes: An undriven pin toggles each cycle so stale levels never match
`timescale 1ns/1ps
module pin_far_end
(
    // Clock
    input  wire logic ref_clk,
    // Pin
    input  wire logic pin_o,
    input  wire logic pin_oe,
    input  wire logic ext_en,
    input  wire logic ext_level,
    output logic      pin_i
);
    logic float_lvl = 1'b0;

    always @(posedge ref_clk)
        float_lvl <= ~float_lvl;

    // Bench only enables the far driver for codes that leave the pin undriven
    assign pin_i = pin_oe ? pin_o : (ext_en ? ext_level : float_lvl);
endmodule

// *** sim/dac_filter_mute_gpio_config_tb.sv ***
// Purpose: Self-checking bench for the filter, mute and pin bank
// Assumes: Register strobes come straight from the bench
// Notes: Read data is checked by a monitor against queued notes
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
        end \
    end
module dac_filter_mute_gpio_config_tb;
    import dac_cfg_pkg::*;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    reg_req_t   reg_req = '0;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    // present, emph valid, dsd, automute, lock, vol min, grounded
    logic [6:0] dev = '0;
    logic       conv_clk = 1'b0;
    filt_cfg_t  filt_cfg;
    logic       input_toggle;
    logic       aux_converter_input;
    logic       aux_converter_sel;
    logic       pin_i;
    logic       pin_o;
    logic       pin_oe;
    logic       ext_en = 1'b0;
    logic       ext_level = 1'b0;
    logic [7:0] r6 = 8'h4A;
    logic [7:0] r7 = 8'h40;
    logic [3:0] code = 4'h8;
    logic       inv;
    logic       exp_oe;
    logic [7:0] notes[$];
    logic [7:0] raddr[6] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0B, 8'h20};
    logic [7:0] rrst[6] = '{8'h4A, 8'h40, 8'h88, 8'h88, 8'h00, 8'h00};
    integer     seed = 32'h0c0c_c3fa;
    int         compares = 0;
    int         miscompares = 0;
    int         cycles = 0;

    dac_filter_mute_gpio_config u_dac_filter_mute_gpio_config
    (
        .ref_clk             (ref_clk),
        .resetn              (resetn),
        .reg_req             (reg_req),
        .reg_rdata           (reg_rdata),
        .reg_rvalid          (reg_rvalid),
        .rx_present          (dev[0]),
        .rx_emph_valid       (dev[1]),
        .dsd_input           (dev[2]),
        .automute_status     (dev[3]),
        .lock_status         (dev[4]),
        .volume_at_min       (dev[5]),
        .outputs_grounded    (dev[6]),
        .conv_clk            (conv_clk),
        .filt_cfg            (filt_cfg),
        .input_toggle        (input_toggle),
        .aux_converter_input (aux_converter_input),
        .aux_converter_sel   (aux_converter_sel),
        .pin_i               (pin_i),
        .pin_o               (pin_o),
        .pin_oe              (pin_oe)
    );

    pin_far_end u_pin_far_end
    (
        .ref_clk   (ref_clk),
        .pin_o     (pin_o),
        .pin_oe    (pin_oe),
        .ext_en    (ext_en),
        .ext_level (ext_level),
        .pin_i     (pin_i)
    );

    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
        conv_clk <= ~conv_clk;

    task automatic final_report;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard, generous against a run of some 380 cycles
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            final_report();
        end
    end

    // Pop once, the compare macro evaluates its expected value twice
    logic [7:0] note;
    always @(negedge ref_clk)
        if (reg_rvalid === 1'b1)
        begin
            note = notes.pop_front();
            `CHK("rdata", note, reg_rdata)
        end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        notes.push_back(e);
        @(posedge ref_clk);
        reg_req.rd <= 1'b0;
    endtask

    // Longer than every registered path, pin synchroniser included
    task automatic look;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    function automatic filt_cfg_t want();
        filt_cfg_t f;
        f.emph_on             = ~r6[6] | (r6[7] & dev[0] & dev[1]);
        f.emph_curve          = r6[5:4];
        f.ramp_speed          = r6[2:0];
        f.fir_response        = r7[7:5];
        f.fir_active          = ~dev[2];
        f.second_stage_cutoff = r7[2:1];
        f.mute_all            = r7[0] | (code == 4'hA && ext_level);
        return f;
    endfunction

    function automatic logic pin_src();
        case (code)
            4'h0:    return dev[3] ^ inv;
            4'h1:    return dev[4] ^ inv;
            4'h2:    return dev[5] ^ inv;
            4'hE:    return dev[6] ^ inv;
            4'hF:    return ~inv;
            default: return inv;
        endcase
    endfunction

    initial
    begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        foreach (raddr[i])
            rd(raddr[i], rrst[i]);
        look();
        `CHK("filt_cfg", want(), filt_cfg)
        for (int i = 0; i < 8; i++)
        begin
            r6 = 8'($random(seed));
            r6[3] = 1'b1;
            if (i >= 4)
                r6[7:6] = 2'b11;
            r7 = 8'($random(seed));
            r7[7:5] = (i == 5) ? 3'b111 : i[2:0];
            r7[2:1] = i[1:0];
            @(posedge ref_clk);
            // DSD only with one of the wider cutoffs
            dev <= {4'h0, (i[1:0] != 2'b00) & i[2], i[0], i[2]};
            wr(8'h06, r6);
            wr(8'h07, r7);
            look();
            `CHK("filt_cfg", want(), filt_cfg)
            rd(8'h06, r6);
        end
        r7 = 8'h40;
        wr(8'h07, r7);
        for (int k = 0; k < 2; k++)
        begin
            inv = k[0];
            wr(8'h0B, {7'h0, inv});
            for (int c = 0; c < 16; c++)
            begin
                code = c[3:0];
                exp_oe = !(c inside {6, [8:12], 13});
                @(posedge ref_clk);
                ext_en <= ~exp_oe;
                dev <= 7'($random(seed)) & 7'h7B;
                ext_level <= 1'($random(seed));
                wr(8'h08, {4'h8, code});
                look();
                `CHK("pin_oe", exp_oe, pin_oe)
                `CHK("filt_cfg", want(), filt_cfg)
                `CHK("aux_sel", code == 4'hD, aux_converter_sel)
                `CHK("toggle", code == 4'h9 && ext_level, input_toggle)
                if (!exp_oe)
                    `CHK("aux_in", ext_level, aux_converter_input)
                if (exp_oe && !(code inside {4'h3, 4'h4, 4'h5}))
                    `CHK("pin", pin_src(), pin_o)
                case (code)
                    4'h3:
                    begin
                        `CHK("clk_hi", ~inv, pin_o)
                        @(negedge ref_clk);
                        #1;
                        `CHK("clk_lo", inv, pin_o)
                    end
                    4'h4:
                    begin
                        rd(ADDR_STATUS, {6'h0, dev[4], dev[3]});
                        look();
                        `CHK("flag_idle", inv, pin_o)
                        @(posedge ref_clk);
                        dev[4] <= ~dev[4];
                        look();
                        `CHK("flag_set", ~inv, pin_o)
                        rd(ADDR_STATUS, {6'h0, dev[4], dev[3]});
                        look();
                        `CHK("flag_clr", inv, pin_o)
                    end
                    4'h5:
                    begin
                        // Looks at high and low phase together tell it from ref_clk
                        `CHK("conv_hi", conv_clk ^ inv, pin_o)
                        @(negedge ref_clk);
                        #1;
                        `CHK("conv_lo", conv_clk ^ inv, pin_o)
                    end
                    4'h8:
                        rd(ADDR_PIN_LEVEL, {7'h0, ext_level});
                    default:
                        ;
                endcase
            end
        end
        look();
        final_report();
    end
endmodule
